// >>> rtl/supervisor_pkg.sv
// Purpose: Shared constants for the supervisor watchdog and reset generator.
// Assumes: core_clk at 100 MHz; a 1 ms tick is derived from it.
// Notes: The rules below carry no tags in the logic that carries them out.
// Operation
// - Active-high reset rises on supply fault, watchdog expiry or long manual press.
// - Active-low open-drain reset pulls low under the same three causes.
// - Both resets stay asserted one full hold period after the cause ends.
// - Hold period after supply recovery lasts at least 250 ms.
// - Watchdog timeout is 150 ms grounded, 600 ms open, 1.2 s tied high.
// - Host kicks with a falling edge each period, otherwise reset is asserted.
// - Manual reset is debounced: under 1 ms ignored, 20 ms or more resets.
// - Margin select grounded picks 5 percent, tied high picks 10 percent threshold.
// - Any falling edge on the kick input, even 75 ns wide, restarts the watchdog.
`default_nettype none
package supervisor_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 17;
  localparam int WD_W = 11;
  localparam int HOLD_W = 9;
  localparam int MR_W = 5;
  localparam int WD_GND_MS = 150;
  localparam int WD_OPEN_MS = 600;
  localparam int WD_VCC_MS = 1200;
  localparam int HOLD_MIN_MS = 250;
  // One extra tick covers the unknown phase of the first tick.
  localparam int HOLD_TICKS = HOLD_MIN_MS + 1;
  localparam int MR_IGNORE_MS = 1;
  localparam int MR_ASSERT_MS = 20;
  localparam int MR_DEBOUNCE_TICKS = 10;
  localparam logic [1:0] TSEL_GND = 2'h0;
  localparam logic [1:0] TSEL_OPEN = 2'h1;
  localparam logic [1:0] TSEL_VCC = 2'h2;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] WDCOUNT_OFF = 8'h08;
  localparam int CTRL_KICK_BIT = 0;
  localparam int STATUS_RST_BIT = 0;
  localparam int STATUS_FAULT_BIT = 1;
  localparam int STATUS_MANUAL_BIT = 2;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;
  typedef enum logic [1:0] {
    SUP_RUN = 2'b00,
    SUP_CAUSE = 2'b01,
    SUP_HOLD = 2'b10
  } sup_state_e;
endpackage
`default_nettype wire

// >>> rtl/debounce_if.sv
// Purpose: Carries tick, synchronised manual level and pressed flag.
// Assumes: All signals belong to core_clk.
// Notes: The top drives tick and level_n; the filter answers pressed.
`default_nettype none
interface debounce_if;
  logic tick;
  logic level_n;
  logic pressed;
  modport ctl (output tick, output level_n, input pressed);
  modport deb (input tick, input level_n, output pressed);
endinterface
`default_nettype wire

// >>> rtl/manual_debounce.sv
// Purpose: Filters the manual reset level into a pressed flag.
// Assumes: level_n is already synchronised; tick is a one-cycle 1 ms pulse.
// Notes: Pressed needs MR_DEBOUNCE_TICKS consecutive low ticks; a high clears it.
`default_nettype none
module manual_debounce
  import supervisor_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rstn,
  debounce_if.deb db
);
  typedef struct packed {
    logic [MR_W-1:0] cnt;
    logic pressed;
  } deb_s;
  deb_s s;
  deb_s next_s;

  always_comb
  begin
    next_s = s;
    if (db.level_n)
    begin
      next_s = '0;
    end
    else if (db.tick && !s.pressed)
    begin
      if (s.cnt == MR_W'(MR_DEBOUNCE_TICKS - 1))
      begin
        next_s.pressed = 1'b1;
      end
      else
      begin
        next_s.cnt = s.cnt + MR_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge sys_rstn)
  begin
    if (!sys_rstn)
      s <= '0;
    else
      s <= next_s;
  end

  assign db.pressed = s.pressed;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!sys_rstn);

  property p_press_needs_low;
    $rose(s.pressed) |-> $past(!db.level_n) && $past(s.cnt) == MR_W'(MR_DEBOUNCE_TICKS - 1);
  endproperty
  a_press_needs_low: assert property (p_press_needs_low)
    else $error("Manual reset pressed without a full low interval.");
endmodule
`default_nettype wire

// >>> rtl/supervisor_watchdog_reset.sv
// Purpose: Supply, watchdog and manual reset supervisor with an AHB-Lite status port.
// Assumes: Pins are asynchronous and pass two flip-flops; hready is the single slave's own.
// Notes: Reset leaves the block asserting reset for a full hold period, as on power-up.
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`default_nettype none
module supervisor_watchdog_reset
  import supervisor_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic supply_fault,
  input wire logic watchdog_kick_n,
  input wire logic manual_reset_n,
  input wire logic [1:0] timeout_select,
  input wire logic supply_margin_select,
  output logic supply_threshold_sel,
  output logic rst,
  output logic rst_n_o,
  output logic rst_n_oe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  typedef struct packed {
    logic [1:0] fault_sync;
    logic [2:0] kick_sync;
    logic [1:0] mr_sync;
    logic [1:0] tsel_meta;
    logic [1:0] tsel;
    logic [1:0] margin_sync;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [WD_W-1:0] wd_cnt;
    logic [HOLD_W-1:0] hold_cnt;
    sup_state_e state;
    logic rst_act;
    logic wr_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
  } sup_s;

  localparam sup_s STATE_INIT = '{
    state: SUP_HOLD, rst_act: 1'b1, hold_cnt: HOLD_W'(HOLD_TICKS), default: '0};

  logic [1:0] rst_sync;
  logic sys_rstn;
  sup_s s;
  sup_s next_s;
  logic [WD_W-1:0] wd_limit;
  logic kick_edge;
  logic sw_kick;
  logic wd_expire;
  logic level_cause;
  logic addr_valid;
  debounce_if db_bus ();

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync <= RST_SYNC_INIT;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign sys_rstn = rst_sync[1];

  manual_debounce deb_u (
    .core_clk(core_clk),
    .sys_rstn(sys_rstn),
    .db(db_bus.deb)
  );
  assign db_bus.tick = s.tick;
  assign db_bus.level_n = s.mr_sync[1];

  always_comb
  begin
    unique case (s.tsel)
      TSEL_GND: wd_limit = WD_W'(WD_GND_MS);
      TSEL_VCC: wd_limit = WD_W'(WD_VCC_MS);
      default: wd_limit = WD_W'(WD_OPEN_MS);
    endcase
  end

  assign kick_edge = s.kick_sync[2] && !s.kick_sync[1];
  assign sw_kick = s.wr_pend && s.addr == CTRL_OFF && hwdata[CTRL_KICK_BIT];
  // A count left above a newly shortened limit must still expire, not wrap around.
  assign wd_expire = s.tick && (s.wd_cnt + WD_W'(1) >= wd_limit);
  assign level_cause = s.fault_sync[1] || db_bus.pressed;
  assign addr_valid = hsel && htrans[1] && hready;

  always_comb
  begin
    next_s = s;
    next_s.fault_sync = {s.fault_sync[0], supply_fault};
    next_s.kick_sync = {s.kick_sync[1:0], watchdog_kick_n};
    next_s.mr_sync = {s.mr_sync[0], manual_reset_n};
    next_s.tsel_meta = timeout_select;
    next_s.tsel = s.tsel_meta;
    next_s.margin_sync = {s.margin_sync[0], supply_margin_select};
    next_s.tick = s.tick_cnt == TICK_W'(TICK_LEN - 1);
    next_s.tick_cnt = next_s.tick ? '0 : s.tick_cnt + TICK_W'(1);
    unique case (s.state)
      SUP_RUN:
      begin
        if (level_cause || wd_expire)
        begin
          next_s.state = SUP_CAUSE;
          next_s.wd_cnt = '0;
        end
        else if (kick_edge || sw_kick)
          next_s.wd_cnt = '0;
        else if (s.tick)
          next_s.wd_cnt = s.wd_cnt + WD_W'(1);
      end
      SUP_CAUSE:
      begin
        next_s.wd_cnt = '0;
        next_s.hold_cnt = HOLD_W'(HOLD_TICKS);
        if (!level_cause)
          next_s.state = SUP_HOLD;
      end
      SUP_HOLD:
      begin
        next_s.wd_cnt = '0;
        if (level_cause)
          next_s.state = SUP_CAUSE;
        else if (s.tick)
        begin
          if (s.hold_cnt == HOLD_W'(1))
            next_s.state = SUP_RUN;
          else
            next_s.hold_cnt = s.hold_cnt - HOLD_W'(1);
        end
      end
      default: next_s.state = SUP_HOLD;
    endcase
    next_s.rst_act = next_s.state != SUP_RUN;
    next_s.wr_pend = addr_valid && hwrite;
    if (addr_valid)
      next_s.addr = haddr[7:0];
    if (addr_valid && !hwrite)
    begin
      next_s.rdata = READ_IDLE;
      if (haddr[7:0] == STATUS_OFF)
      begin
        next_s.rdata[STATUS_RST_BIT] = s.rst_act;
        next_s.rdata[STATUS_FAULT_BIT] = s.fault_sync[1];
        next_s.rdata[STATUS_MANUAL_BIT] = db_bus.pressed;
      end
      else if (haddr[7:0] == WDCOUNT_OFF)
        next_s.rdata[WD_W-1:0] = s.wd_cnt;
    end
  end

  always_ff @(posedge core_clk or negedge sys_rstn)
  begin
    if (!sys_rstn)
      s <= STATE_INIT;
    else
      s <= next_s;
  end

  assign rst = s.rst_act;
  assign rst_n_o = 1'b0;
  assign rst_n_oe = s.rst_act;
  assign supply_threshold_sel = s.margin_sync[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;

  logic [31:0] hold_span;
  always_ff @(posedge core_clk or negedge sys_rstn)
  begin
    if (!sys_rstn)
      hold_span <= '0;
    else if (s.state != SUP_HOLD)
      hold_span <= '0;
    else if (s.tick)
      hold_span <= hold_span + 32'h1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!sys_rstn);

  sequence s_fault_seen;
    s.fault_sync[1] && s.state == SUP_RUN;
  endsequence
  sequence s_cause_gone;
    s.state == SUP_CAUSE ##1 s.state == SUP_HOLD;
  endsequence

  property p_fault_asserts;
    s_fault_seen |=> rst;
  endproperty
  a_fault_asserts: assert property (p_fault_asserts)
    else $error("Supply fault did not raise reset.");

  property p_pins_agree;
    rst_n_oe == rst && !rst_n_o;
  endproperty
  a_pins_agree: assert property (p_pins_agree)
    else $error("Open-drain reset disagrees with active-high reset.");

  property p_hold_after_cause;
    s_cause_gone |-> rst && s.hold_cnt == HOLD_W'(HOLD_TICKS);
  endproperty
  a_hold_after_cause: assert property (p_hold_after_cause)
    else $error("Hold period did not start at full length.");

  property p_hold_length;
    $fell(rst) |-> $past(hold_span) >= 32'(HOLD_MIN_MS);
  endproperty
  a_hold_length: assert property (p_hold_length)
    else $error("Reset released before the minimum hold time.");

  property p_limit_select;
    s.tsel == TSEL_GND |-> wd_limit == WD_W'(WD_GND_MS);
  endproperty
  a_limit_select: assert property (p_limit_select)
    else $error("Grounded select did not give the short timeout.");

  property p_expire_resets;
    s.state == SUP_RUN && wd_expire && !level_cause |=> rst ##1 s.state == SUP_HOLD;
  endproperty
  a_expire_resets: assert property (p_expire_resets)
    else $error("Watchdog expiry did not assert reset.");

  property p_margin_follows;
    supply_margin_select [*3] |-> supply_threshold_sel;
  endproperty
  a_margin_follows: assert property (p_margin_follows)
    else $error("Threshold select did not follow the margin pin.");

  property p_kick_clears;
    s.state == SUP_RUN && kick_edge && !level_cause && !wd_expire |=> s.wd_cnt == '0;
  endproperty
  a_kick_clears: assert property (p_kick_clears)
    else $error("Kick edge did not restart the watchdog.");

  property p_tick_single;
    s.tick |=> !s.tick;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("Time base tick lasted more than one cycle.");

  property p_cleared_in_reset;
    rst |=> s.wd_cnt == '0 || !rst;
  endproperty
  a_cleared_in_reset: assert property (p_cleared_in_reset)
    else $error("Watchdog counted while reset was asserted.");
endmodule
`default_nettype wire

// >>> verif/host_model.sv
// Purpose: Host processor model that kicks the watchdog and watches the reset line.
// Assumes: The reset line is open drain; the bench resolves it with a pull-up.
// Notes: Each kick is a three-cycle low pulse at the end of every gap.
`default_nettype none
module host_model
(
  input wire logic core_clk,
  input wire logic kick_en,
  input wire logic [15:0] gap,
  input wire logic rst_line_n,
  output logic watchdog_kick_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt = 16'h0;
  logic kick_q = 1'b1;
  assign watchdog_kick_n = kick_q;
  always @(posedge core_clk)
  begin
    // A host in reset does not kick; it starts its gap afresh when the line is released.
    if (!kick_en || !rst_line_n)
    begin
      cnt <= 16'h0;
      kick_q <= 1'b1;
    end
    else
    begin
      cnt <= (cnt == gap - 16'h1) ? 16'h0 : cnt + 16'h1;
      kick_q <= (cnt < gap - 16'h3);
    end
  end
endmodule
`default_nettype wire

// >>> verif/supervisor_watchdog_reset_test.sv
// Purpose: Self-checking bench for the supervisor watchdog and reset block.
// Assumes: TICK_LEN is shortened to 16 cycles; the host model kicks every 100 ticks.
// Notes: Margins of two ticks cover the unknown phase of the tick.
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module supervisor_watchdog_reset_test
  import supervisor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TL = 16;
  localparam logic [15:0] GAP = 16'(100 * TL);
  logic core_clk, rstn, supply_fault, manual_reset_n, supply_margin_select, kick_en;
  logic watchdog_kick_n, rst_line_n, supply_threshold_sel, rst, rst_n_o, rst_n_oe;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] timeout_select, htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int num_errors, cmp_count, cycles;
  assign rst_line_n = rst_n_oe ? rst_n_o : 1'b1;
  supervisor_watchdog_reset #(.TICK_LEN(TL)) u_dut (.core_clk, .rstn, .supply_fault,
    .watchdog_kick_n, .manual_reset_n, .timeout_select, .supply_margin_select,
    .supply_threshold_sel, .rst, .rst_n_o, .rst_n_oe, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);
  host_model u_host (.core_clk, .kick_en, .gap(GAP), .rst_line_n, .watchdog_kick_n);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic wt(input int n);
    repeat (n * TL) @(posedge core_clk);
  endtask
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  task automatic hold_end;
    wt(HOLD_TICKS - 2);
    `CHK(rst, 1'b1)
    wt(4);
    `CHK({rst, rst_line_n}, 2'h1)
  endtask
  task automatic t_powerup;
    hold_end();
    supply_margin_select <= 1'b1;
    wt(1);
    `CHK(supply_threshold_sel, 1'b1)
    supply_margin_select <= 1'b0;
    wt(1);
    `CHK(supply_threshold_sel, 1'b0)
    ahb(32'h40, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    $display("powerup test done");
  endtask
  task automatic t_fault;
    supply_fault <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK({rst, rst_n_oe, rst_line_n}, 3'h6)
    ahb(32'(STATUS_OFF), 1'b0, 32'h0);
    `CHK(rd[1:0], 2'h3)
    supply_fault <= 1'b0;
    hold_end();
    $display("fault test done");
  endtask
  task automatic t_manual;
    manual_reset_n <= 1'b0;
    repeat (TL / 2) @(posedge core_clk);
    manual_reset_n <= 1'b1;
    wt(12);
    `CHK(rst, 1'b0)
    manual_reset_n <= 1'b0;
    wt(20);
    `CHK({rst, rst_n_oe}, 2'h3)
    ahb(32'(STATUS_OFF), 1'b0, 32'h0);
    `CHK(rd[2:0], 3'h5)
    manual_reset_n <= 1'b1;
    hold_end();
    $display("manual test done");
  endtask
  task automatic t_watchdog;
    logic [1:0] sel[4] = '{TSEL_GND, TSEL_OPEN, TSEL_VCC, 2'h3};
    int lim[4] = '{WD_GND_MS, WD_OPEN_MS, WD_VCC_MS, WD_OPEN_MS};
    for (int i = 0; i < 4; i++)
    begin
      kick_en <= 1'b0;
      timeout_select <= sel[i];
      wt(1);
      ahb(32'(CTRL_OFF), 1'b1, 32'h1);
      wt(lim[i] - 2);
      `CHK(rst, 1'b0)
      wt(4);
      `CHK(rst, 1'b1)
      ahb(32'(WDCOUNT_OFF), 1'b0, 32'h0);
      `CHK(rd[WD_W-1:0], 11'h0)
      kick_en <= 1'b1;
      wt(HOLD_TICKS + 2);
      `CHK(rst, 1'b0)
      ahb(32'(WDCOUNT_OFF), 1'b0, 32'h0);
      // Only a few ticks have passed since release, so a fresh count is small but running.
      `CHK(rd[WD_W-1:3] == 8'h0 && rd[2:0] != 3'h0, 1'b1)
    end
    $display("watchdog test done");
  endtask
  task automatic t_keepalive;
    timeout_select <= TSEL_GND;
    wt(390);
    `CHK(rst, 1'b0)
    $display("keepalive test done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    rstn = 1'b0;
    supply_fault = 1'b0;
    manual_reset_n = 1'b1;
    timeout_select = TSEL_VCC;
    supply_margin_select = 1'b0;
    kick_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_powerup();
    t_fault();
    t_manual();
    t_watchdog();
    t_keepalive();
    conclude();
  end
endmodule
`default_nettype wire
